/* File: shared/ssi_encoder_map.vh */
`ifndef SSI_ENCODER_MAP_VH
`define SSI_ENCODER_MAP_VH
// ==========================================================
// word layout
`define SSI_WORD_BITS 13
`define SSI_POS_MSB 12
`define SSI_CNT_W 4
`define SSI_CNT_LAST 4'h0
`define SSI_CNT_LOAD 4'hC
`define SSI_POS_ZERO 13'h0000
// ==========================================================
// clock rate and timing figures
`define SSI_MCLK_MHZ 100
`define SSI_MONO_US 15
// two sync stages, edge detect and the exit edge of the tail state
`define SSI_SYNC_LAT 4
`define SSI_LSB_HOLD_NS 1000
`define SSI_DIR_SETTLE_MS 20
`define SSI_ZERO_HOLD_MS 10
`define SSI_READY_MS 250
// ==========================================================
// counter widths
`define SSI_MONO_W 11
`define SSI_LONG_W 25
// ==========================================================
// fsm states
`define SSI_ST_W 2
`define SSI_ST_IDLE 2'h0
`define SSI_ST_SHIFT 2'h1
`define SSI_ST_TAIL 2'h2
`endif

/* File: rtl/ssi_absolute_position_encoder.v */
// Operation
// RULE_01: idle clock and data rest high
// RULE_02: first falling edge captures position, special bit
// RULE_03: first rising edge presents the MSB
// RULE_04: each later rising edge shifts next bit
// RULE_05: after LSB data low until timeout
// RULE_06: monoflop timeout at most 15 us
// RULE_07: last falling edge restarts the monoflop
// RULE_08: controller waits for data high again
// RULE_09: controller keeps edge gaps below timeout
// RULE_10: word carries 13 position bits
// RULE_11: Gray code, clockwise ascending by default
// RULE_12: continued clocking repeats the captured word
// RULE_13: late 26th pulse sends a fresh word
// RULE_14: repeat mode works up to 13 bits
// RULE_15: controller clock at most 500 kbit/s; the bench controller model clocks with 160 ns periods (6.25 MHz)
// RULE_16: direction input selects ascending direction
// RULE_17: direction and zero-set active high
// RULE_18: direction change effective within 20 ms
// RULE_19: zero-set held over 10 ms presets zero
// RULE_20: valid data within 250 ms after power
// RULE_21: controller reads with 13-pulse bundles
`timescale 1ns/10ps
`include "ssi_encoder_map.vh"

module ssi_absolute_position_encoder #(
    parameter [24:0] DIR_CYC =
        `SSI_DIR_SETTLE_MS * 1000 * `SSI_MCLK_MHZ,
    parameter [24:0] ZERO_CYC =
        `SSI_ZERO_HOLD_MS * 1000 * `SSI_MCLK_MHZ + 1,
    parameter [24:0] READY_CYC =
        `SSI_READY_MS * 1000 * `SSI_MCLK_MHZ - 1
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // serial link
    input wire ssi_clk_i,
    output reg ssi_data_o,
    // sensor position stream
    input wire [`SSI_POS_MSB:0] pos_data_i,
    input wire pos_valid_i,
    output wire pos_ready_o,
    input wire spec_bit_i,
    // function inputs
    input wire dir_ccw_i,
    input wire zero_set_i,
    // status
    output reg spec_bit_o,
    output reg ready_o,
    output wire frame_busy_o
);

// ==========================================================
// timing counts
// monoflop rounds down and absorbs the edge detection delay
localparam [10:0] MONO_CYC =
    `SSI_MONO_US * `SSI_MCLK_MHZ - `SSI_SYNC_LAT;
localparam [10:0] LSB_CYC =
    `SSI_LSB_HOLD_NS * `SSI_MCLK_MHZ / 1000;

// ==========================================================
// input synchronisers
reg clk_s1_ff, clk_s2_ff, clk_d_ff;
reg dir_s1_ff, dir_s2_ff;
reg zero_s1_ff, zero_s2_ff;

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        clk_s1_ff <= 1'b1;
        clk_s2_ff <= 1'b1;
        clk_d_ff <= 1'b1;
        dir_s1_ff <= 1'b0;
        dir_s2_ff <= 1'b0;
        zero_s1_ff <= 1'b0;
        zero_s2_ff <= 1'b0;
    end else begin
        clk_s1_ff <= ssi_clk_i;
        clk_s2_ff <= clk_s1_ff;
        clk_d_ff <= clk_s2_ff;
        dir_s1_ff <= dir_ccw_i;
        dir_s2_ff <= dir_s1_ff;
        zero_s1_ff <= zero_set_i;
        zero_s2_ff <= zero_s1_ff;
    end
end

wire clk_fall = clk_d_ff & ~clk_s2_ff;
wire clk_rise = ~clk_d_ff & clk_s2_ff;

// ==========================================================
// power-up delay
reg [`SSI_LONG_W-1:0] rdy_cnt_ff;

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rdy_cnt_ff <= {`SSI_LONG_W{1'b0}};
        ready_o <= 1'b0;
    end else if (!ready_o) begin
        // RULE_20: ready after delay
        rdy_cnt_ff <= rdy_cnt_ff + 1'b1;
        ready_o <= (rdy_cnt_ff >= READY_CYC);
    end
end

// ==========================================================
// direction select settling
// a level must stay put for the full window, so glitches are ignored
reg dir_ff;
reg [`SSI_LONG_W-1:0] dir_cnt_ff;

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        dir_ff <= 1'b0;
        dir_cnt_ff <= {`SSI_LONG_W{1'b0}};
    end else if (dir_s2_ff == dir_ff) begin
        dir_cnt_ff <= {`SSI_LONG_W{1'b0}};
    end else if (dir_cnt_ff >= DIR_CYC - 1'b1) begin
        // RULE_18: settled within window
        dir_ff <= dir_s2_ff;
        dir_cnt_ff <= {`SSI_LONG_W{1'b0}};
    end else begin
        dir_cnt_ff <= dir_cnt_ff + 1'b1;
    end
end

// ==========================================================
// two-entry position buffer
reg [`SSI_POS_MSB:0] buf_mem [0:1];
reg wr_ptr_ff, rd_ptr_ff;
reg [1:0] buf_cnt_ff;
reg [`SSI_POS_MSB:0] pos_cur_ff;
reg [`SSI_ST_W-1:0] state_ff;

// positions are not consumed mid-frame, so a held-off sensor waits
wire buf_out_valid = (buf_cnt_ff != 2'h0);
wire buf_out_ready = (state_ff == `SSI_ST_IDLE);
wire buf_pop = buf_out_valid & buf_out_ready;
assign pos_ready_o = (buf_cnt_ff != 2'h2);
wire buf_push = pos_valid_i & pos_ready_o;

always @(posedge mclk_i) begin
    if (buf_push) begin
        buf_mem[wr_ptr_ff] <= pos_data_i;
    end
end

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
        buf_cnt_ff <= 2'h0;
        pos_cur_ff <= `SSI_POS_ZERO;
    end else begin
        if (buf_push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
        end
        if (buf_pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
            pos_cur_ff <= buf_mem[rd_ptr_ff];
        end
        buf_cnt_ff <= buf_cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
    end
end

// ==========================================================
// zero-set qualification
reg [`SSI_LONG_W-1:0] zero_cnt_ff;
reg zero_done_ff;
reg [`SSI_POS_MSB:0] offset_ff;

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        zero_cnt_ff <= {`SSI_LONG_W{1'b0}};
        zero_done_ff <= 1'b0;
        offset_ff <= `SSI_POS_ZERO;
    end else if (!zero_s2_ff) begin
        zero_cnt_ff <= {`SSI_LONG_W{1'b0}};
        zero_done_ff <= 1'b0;
    end else if (!zero_done_ff) begin
        // RULE_19: held long enough, preset
        if (zero_cnt_ff >= ZERO_CYC - 1'b1) begin
            offset_ff <= pos_cur_ff;
            zero_done_ff <= 1'b1;
        end else begin
            zero_cnt_ff <= zero_cnt_ff + 1'b1;
        end
    end
end

// ==========================================================
// reported position
reg [`SSI_POS_MSB:0] pos_rel;
reg [`SSI_POS_MSB:0] pos_dir;
reg [`SSI_POS_MSB:0] pos_gray;

always @* begin
    pos_rel = pos_cur_ff - offset_ff;
    // RULE_16: direction reverses count
    // RULE_17: high level means ccw ascending
    pos_dir = dir_ff ? (`SSI_POS_ZERO - pos_rel) : pos_rel;
    // RULE_11: Gray conversion
    pos_gray = pos_dir ^ (pos_dir >> 1);
end

// ==========================================================
// serial transmit state machine
reg [`SSI_POS_MSB:0] word_ff, nxt_word;
reg [`SSI_POS_MSB:0] shift_ff, nxt_shift;
reg [`SSI_CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
reg [`SSI_MONO_W-1:0] mono_cnt_ff, nxt_mono_cnt;
reg [`SSI_MONO_W-1:0] hold_cnt_ff, nxt_hold_cnt;
reg [`SSI_ST_W-1:0] nxt_state;
reg nxt_data, nxt_spec;

assign frame_busy_o = (state_ff != `SSI_ST_IDLE);

always @* begin
    nxt_state = state_ff;
    nxt_word = word_ff;
    nxt_shift = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_mono_cnt = mono_cnt_ff;
    nxt_hold_cnt = hold_cnt_ff;
    nxt_data = ssi_data_o;
    nxt_spec = spec_bit_o;
    // RULE_07: every falling edge retriggers
    if (clk_fall) begin
        nxt_mono_cnt = MONO_CYC;
    end else if (mono_cnt_ff != {`SSI_MONO_W{1'b0}}) begin
        nxt_mono_cnt = mono_cnt_ff - 1'b1;
    end
    case (state_ff)
        `SSI_ST_IDLE: begin
            // RULE_01: line rests high
            nxt_data = 1'b1;
            // RULE_02: capture on first falling edge
            // RULE_13: late pulse lands here, fresh word
            if (clk_fall && ready_o) begin
                nxt_word = pos_gray;
                nxt_shift = pos_gray;
                nxt_spec = spec_bit_i;
                nxt_bit_cnt = `SSI_CNT_LOAD;
                nxt_state = `SSI_ST_SHIFT;
            end
        end
        `SSI_ST_SHIFT: begin
            if (clk_rise) begin
                // RULE_03: MSB first
                // RULE_04: then next lower bit
                // RULE_10: thirteen bits per word
                nxt_data = shift_ff[`SSI_POS_MSB];
                nxt_shift = {shift_ff[`SSI_POS_MSB-1:0], 1'b0};
                if (bit_cnt_ff == `SSI_CNT_LAST) begin
                    nxt_hold_cnt = LSB_CYC;
                    nxt_state = `SSI_ST_TAIL;
                end else begin
                    nxt_bit_cnt = bit_cnt_ff - 1'b1;
                end
            end else if (mono_cnt_ff == {`SSI_MONO_W{1'b0}}
                         && !clk_fall) begin
                // aborted bundle: timeout releases the line
                nxt_data = 1'b1;
                nxt_state = `SSI_ST_IDLE;
            end
        end
        `SSI_ST_TAIL: begin
            if (hold_cnt_ff != {`SSI_MONO_W{1'b0}}) begin
                nxt_hold_cnt = hold_cnt_ff - 1'b1;
            end
            if (clk_rise) begin
                // RULE_12: unbroken clocking repeats word
                // RULE_14: ring covers the full 13 bits
                nxt_data = word_ff[`SSI_POS_MSB];
                nxt_shift = {word_ff[`SSI_POS_MSB-1:0], 1'b0};
                nxt_bit_cnt = `SSI_CNT_LOAD - 1'b1;
                nxt_state = `SSI_ST_SHIFT;
            end else if (mono_cnt_ff == {`SSI_MONO_W{1'b0}}
                         && !clk_fall) begin
                // RULE_06: timeout ends the frame
                nxt_data = 1'b1;
                nxt_state = `SSI_ST_IDLE;
            end else if (hold_cnt_ff == {`SSI_MONO_W{1'b0}}) begin
                // RULE_05: low until timeout
                nxt_data = 1'b0;
            end
        end
        default: begin
            nxt_data = 1'b1;
            nxt_state = `SSI_ST_IDLE;
        end
    endcase
end

always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        state_ff <= `SSI_ST_IDLE;
        word_ff <= `SSI_POS_ZERO;
        shift_ff <= `SSI_POS_ZERO;
        bit_cnt_ff <= {`SSI_CNT_W{1'b0}};
        mono_cnt_ff <= {`SSI_MONO_W{1'b0}};
        hold_cnt_ff <= {`SSI_MONO_W{1'b0}};
        ssi_data_o <= 1'b1;
        spec_bit_o <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        word_ff <= nxt_word;
        shift_ff <= nxt_shift;
        bit_cnt_ff <= nxt_bit_cnt;
        mono_cnt_ff <= nxt_mono_cnt;
        hold_cnt_ff <= nxt_hold_cnt;
        ssi_data_o <= nxt_data;
        spec_bit_o <= nxt_spec;
    end
end

endmodule // ssi_absolute_position_encoder

/* File: sim/ssi_encoder_monitor_monitor.sv */
`timescale 1ns/10ps
`include "ssi_encoder_map.vh"
// ==========================================
// link checker
module ssi_encoder_monitor (
    // clock and reset
    input wire mclk_i,
    input wire rst_n_i,
    // design ports
    input wire ssi_clk_i,
    input wire ssi_data_o,
    input wire [`SSI_POS_MSB:0] pos_data_i,
    input wire pos_valid_i,
    input wire pos_ready_o,
    input wire spec_bit_i,
    input wire dir_ccw_i,
    input wire zero_set_i,
    input wire spec_bit_o,
    input wire ready_o,
    input wire frame_busy_o
);
    reg clk_q_ff;
    reg [11:0] gap_ff;
    // gap from pin fall, so sync delay counts against the timeout
    always @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_q_ff <= 1'b1;
            gap_ff <= 12'h000;
        end else begin
            clk_q_ff <= ssi_clk_i;
            if (clk_q_ff && !ssi_clk_i)
                gap_ff <= 12'h000;
            else if (frame_busy_o && gap_ff != 12'hFFF)
                gap_ff <= gap_ff + 12'h001;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_fall_idle;
        $fell(ssi_clk_i) && !frame_busy_o && ready_o;
    endsequence
    sequence s_push_busy;
        pos_valid_i && pos_ready_o && frame_busy_o;
    endsequence
    sequence s_low_phase;
        (frame_busy_o && !ssi_clk_i) [*4];
    endsequence
    a_idle_data_high: assert property (!frame_busy_o |-> ssi_data_o)
        else $error("data not high at idle");
    a_fall_starts_frame: assert property (s_fall_idle |-> ##[1:4] frame_busy_o)
        else $error("falling edge did not start a frame");
    a_spec_bit_capture: assert property ($rose(frame_busy_o) |-> spec_bit_o == spec_bit_i)
        else $error("special bit not captured");
    a_bits_on_rise: assert property (s_low_phase |-> $stable(ssi_data_o))
        else $error("data moved in clock low phase");
    a_tail_low_end: assert property ($fell(frame_busy_o) |-> ssi_data_o && !$past(ssi_data_o))
        else $error("data not low before frame end");
    a_mono_bound: assert property (frame_busy_o |-> gap_ff <= 12'h5DF)
        else $error("monoflop longer than allowed");
    a_mono_restart: assert property ($fell(frame_busy_o) |-> gap_ff inside {[12'h5D2:12'h5DF]})
        else $error("timeout not measured from last fall");
    a_ready_gates: assert property (!ready_o |-> !frame_busy_o)
        else $error("frame before ready");
    a_ready_holds: assert property (ready_o |=> ready_o)
        else $error("ready dropped");
    a_buffer_full: assert property (s_push_busy ##1 s_push_busy |=> !pos_ready_o)
        else $error("buffer took a third word");
endmodule // ssi_encoder_monitor

bind ssi_absolute_position_encoder ssi_encoder_monitor mon_u (.mclk_i,
    .rst_n_i, .ssi_clk_i, .ssi_data_o, .pos_data_i, .pos_valid_i,
    .pos_ready_o, .spec_bit_i, .dir_ccw_i, .zero_set_i, .spec_bit_o,
    .ready_o, .frame_busy_o);

/* File: sim/ssi_ctrl_model.sv */
`timescale 1ns/10ps
// ==========================================
// controller: clock bundles, samples data
module ssi_ctrl_model (
    // clock
    input wire mclk_i,
    // link
    input wire ssi_data_i,
    output reg ssi_clk_o
);
    reg [25:0] rx_bits;
    // set when the device never released the data line
    reg stall_seen;
    initial stall_seen = 1'b0;
    initial ssi_clk_o = 1'b1;
    task automatic bundle(input int n);
        int i;
        begin
            rx_bits = 26'h0000000;
            i = 0;
            while (ssi_data_i !== 1'b1 && i < 2000) begin
                @(negedge mclk_i);
                i++;
            end
            if (i == 2000) stall_seen = 1'b1;
            // 160 ns pulses, n per bundle
            for (i = 0; i < n; i++) begin
                repeat (2) @(negedge mclk_i);
                ssi_clk_o = 1'b0;
                repeat (8) @(negedge mclk_i);
                ssi_clk_o = 1'b1;
                // sample late: data moves 2-3 cycles after rise
                repeat (6) @(negedge mclk_i);
                rx_bits = {rx_bits[24:0], ssi_data_i};
            end
        end
    endtask
endmodule // ssi_ctrl_model

/* File: sim/ssi_absolute_position_encoder_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ==========================================
// bench
module ssi_absolute_position_encoder_test;
    reg mclk_i, rst_n_i, pos_valid_i, spec_bit_i, dir_ccw_i, zero_set_i;
    reg [12:0] pos_data_i, cur, g;
    reg [31:0] seed;
    wire ssi_clk_i, ssi_data_o, pos_ready_o, spec_bit_o, ready_o;
    wire frame_busy_o;
    integer mismatches, tests_run, off, ccw, i, j, k;
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    function [12:0] expw(input [12:0] p);
        reg [12:0] r;
        begin
            r = p - off[12:0];
            if (ccw) r = 13'h0000 - r;
            expw = r ^ (r >> 1);
        end
    endfunction
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    ssi_absolute_position_encoder #(.DIR_CYC(25'h14), .ZERO_CYC(25'h0B),
        .READY_CYC(25'h0A)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .ssi_clk_i(ssi_clk_i), .ssi_data_o(ssi_data_o),
        .pos_data_i(pos_data_i), .pos_valid_i(pos_valid_i),
        .pos_ready_o(pos_ready_o), .spec_bit_i(spec_bit_i),
        .dir_ccw_i(dir_ccw_i), .zero_set_i(zero_set_i),
        .spec_bit_o(spec_bit_o), .ready_o(ready_o),
        .frame_busy_o(frame_busy_o));
    ssi_ctrl_model ctrl_u (.mclk_i(mclk_i), .ssi_data_i(ssi_data_o),
        .ssi_clk_o(ssi_clk_i));
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task push(input [12:0] p);
        begin
            @(negedge mclk_i);
            pos_data_i = p;
            pos_valid_i = 1'b1;
            @(negedge mclk_i);
            `CHK(pos_ready_o, 1'b1)
            pos_valid_i = 1'b0;
            repeat (4) @(negedge mclk_i);
        end
    endtask
    task frame(input int n, input [25:0] exp);
        begin
            ctrl_u.bundle(n);
            `CHK(ctrl_u.rx_bits, exp)
            `CHK(spec_bit_o, spec_bit_i)
            repeat (100) @(negedge mclk_i);
            `CHK(ssi_data_o, 1'b0)
            k = 0;
            while (frame_busy_o !== 1'b0 && k < 2000) begin
                @(negedge mclk_i);
                k++;
            end
            if (k == 2000 || ctrl_u.stall_seen) begin
                mismatches++;
                report_and_stop;
            end
            `CHK(k > 1375 && k < 1392, 1'b1)
            `CHK(ssi_data_o, 1'b1)
        end
    endtask
    initial begin
        #1000000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        {rst_n_i, pos_valid_i, spec_bit_i, dir_ccw_i, zero_set_i} = 5'h00;
        pos_data_i = 13'h0000;
        seed = 32'h655C;
        {off, ccw, mismatches, tests_run} = 0;
        repeat (8) @(negedge mclk_i);
        `CHK(ssi_data_o, 1'b1)
        `CHK(ready_o, 1'b0)
        rst_n_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        `CHK(ready_o, 1'b1)
        // later frames after a pause are fresh captures
        for (i = 0; i < 3; i++) begin
            seed = xs(seed);
            cur = seed[12:0];
            spec_bit_i = seed[13];
            push(cur);
            frame(13, {13'h0000, expw(cur)});
        end
        g = expw(cur);
        frame(26, {g, g});
        // words arriving mid-frame wait; the last one wins
        fork
            frame(13, {13'h0000, g});
            begin
                j = 0;
                while (frame_busy_o !== 1'b1 && j < 200) begin
                    @(negedge mclk_i);
                    j++;
                end
                if (j == 200) begin
                    mismatches++;
                    report_and_stop;
                end
                seed = xs(seed);
                pos_data_i = seed[12:0];
                pos_valid_i = 1'b1;
                @(negedge mclk_i);
                seed = xs(seed);
                pos_data_i = seed[12:0];
                cur = seed[12:0];
                @(negedge mclk_i);
                pos_valid_i = 1'b0;
                `CHK(pos_ready_o, 1'b0)
            end
        join
        frame(13, {13'h0000, expw(cur)});
        zero_set_i = 1'b1;
        repeat (30) @(negedge mclk_i);
        zero_set_i = 1'b0;
        off = cur;
        frame(13, 26'h0000000);
        seed = xs(seed);
        cur = seed[12:0];
        push(cur);
        dir_ccw_i = 1'b1;
        ccw = 1;
        repeat (40) @(negedge mclk_i);
        frame(13, {13'h0000, expw(cur)});
        report_and_stop;
    end
endmodule // ssi_absolute_position_encoder_test
